// [common/ccac_pkg.sv]
// Constants and query layouts for the class-based cache allocation bank.
// Assumes a single core clock and a register-access port of model-specific style.
// What this block does
// - Leaf 07H sub 0 returns word-2 bit 15 set.
// - Leaf 10H sub 0 lists resources in bits 31:1.
// - Only last-level cache, reported at sub-function 1.
// - Word 1 bits 4:0 give mask length minus one.
// - Word 2 gives mask of shared allocation units.
// - Word 3 bit 1 flags no frequent changes.
// - Word 4 bits 15:0 give highest class number.
// - Mask registers occupy 0C90H through 0D8FH; only 0C90H-0C9FH exist, the rest fault.
// - Association register at 0C8FH, class in 63:32.
// - Too-large class write rejected with fault.
// - Association class resets to zero.
// - Class 0 mask resets to all ones.
// - All registers read and write by register access.
// - Set mask bits allow allocation, clear block.
// - Every cache request tagged with current class.
// - Reserved-bit change on write raises fault.
package ccac_pkg;
   localparam int CCAC_MASK_LEN = 16;
   localparam int CCAC_NUM_CLASS = 16;
   localparam int CCAC_CLASS_W = 4;
   localparam logic [31:0] CCAC_LEAF_FEAT = 32'h0000_0007;
   localparam logic [31:0] CCAC_LEAF_ALLOC = 32'h0000_0010;
   localparam logic [31:0] CCAC_SUB_ENUM = 32'h0000_0000;
   localparam logic [31:0] CCAC_SUB_LLC = 32'h0000_0001;
   localparam int CCAC_FEAT_BIT = 15;
   localparam int CCAC_RES_LLC_BIT = 1;
   localparam int CCAC_NOFREQ_BIT = 1;
   localparam logic [4:0] CCAC_MASK_LEN_M1 = 5'h0f;
   localparam logic [15:0] CCAC_MAX_CLASS = 16'h000f;
   localparam logic [31:0] CCAC_SHARED_MASK_DEF = 32'h0000_0000;
   localparam logic CCAC_NOFREQ_DEF = 1'b0;
   localparam logic [31:0] CCAC_ADDR_ASSOC = 32'h0000_0c8f;
   localparam logic [31:0] CCAC_ADDR_MASK_LO = 32'h0000_0c90;
   localparam logic [31:0] CCAC_ADDR_MASK_HI = 32'h0000_0d8f;
   localparam int CCAC_ASSOC_CLASS_LSB = 32;
   localparam logic [CCAC_CLASS_W-1:0] CCAC_ASSOC_RST = 4'h0;
   localparam logic [CCAC_MASK_LEN-1:0] CCAC_MASK0_RST = 16'hffff;
   localparam logic [CCAC_MASK_LEN-1:0] CCAC_MASKN_RST = 16'h0000;
endpackage : ccac_pkg

// [src/ccac_id_query.sv]
// Identification query answer for the allocation feature.
// Assumes leaf and sub-function inputs are stable while sampled.
`timescale 1ns/1ps
module ccac_id_query
   import ccac_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Query request
   input wire logic id_req_in,
   input wire logic [31:0] id_leaf_in,
   input wire logic [31:0] id_sub_in,
   input wire logic [31:0] shared_mask_in,
   input wire logic no_freq_change_in,
   // Query answer
   output logic id_valid_out,
   output logic [31:0] id_w1_out,
   output logic [31:0] id_w2_out,
   output logic [31:0] id_w3_out,
   output logic [31:0] id_w4_out
);
   wire sel_feat = id_leaf_in == CCAC_LEAF_FEAT && id_sub_in == CCAC_SUB_ENUM;
   wire sel_enum = id_leaf_in == CCAC_LEAF_ALLOC && id_sub_in == CCAC_SUB_ENUM;
   wire sel_llc = id_leaf_in == CCAC_LEAF_ALLOC && id_sub_in == CCAC_SUB_LLC;
   wire [31:0] len_mask = {{(32-CCAC_MASK_LEN){1'b0}}, {CCAC_MASK_LEN{1'b1}}};
   wire [31:0] w1_next = sel_llc ? {27'h0, CCAC_MASK_LEN_M1} : 32'h0;
   wire [31:0] w2_next = sel_feat ? (32'h1 << CCAC_FEAT_BIT) :
      sel_enum ? (32'h1 << CCAC_RES_LLC_BIT) :
      sel_llc ? (shared_mask_in & len_mask) : 32'h0;
   wire [31:0] w3_next = sel_llc ? {30'h0, no_freq_change_in, 1'b0} : 32'h0;
   wire [31:0] w4_next = sel_llc ? {16'h0, CCAC_MAX_CLASS} : 32'h0;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         id_valid_out <= 1'b0;
         id_w1_out <= 32'h0;
         id_w2_out <= 32'h0;
         id_w3_out <= 32'h0;
         id_w4_out <= 32'h0;
      end else begin
         id_valid_out <= id_req_in;
         if (id_req_in) begin
            id_w1_out <= w1_next;
            id_w2_out <= w2_next;
            id_w3_out <= w3_next;
            id_w4_out <= w4_next;
         end
      end
   end
endmodule : ccac_id_query

// [src/ccac_top.sv]
// Per-processor class-allocation registers, query answer and request tagging.
// Assumes one register access at a time, synchronous to clk_in.
`timescale 1ns/1ps
module ccac_top
   import ccac_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Platform straps for the query
   input wire logic [31:0] shared_mask_in,
   input wire logic no_freq_change_in,
   // Identification query
   input wire logic id_req_in,
   input wire logic [31:0] id_leaf_in,
   input wire logic [31:0] id_sub_in,
   output logic id_valid_out,
   output logic [31:0] id_w1_out,
   output logic [31:0] id_w2_out,
   output logic [31:0] id_w3_out,
   output logic [31:0] id_w4_out,
   // Register access
   input wire logic reg_rd_in,
   input wire logic reg_wr_in,
   input wire logic [31:0] reg_addr_in,
   input wire logic [63:0] reg_wdata_in,
   output logic reg_done_out,
   output logic [63:0] reg_rdata_out,
   output logic reg_gp_fault_out,
   // Cache request tagging
   input wire logic cache_req_in,
   output logic cache_req_out,
   output logic [CCAC_CLASS_W-1:0] service_class_out,
   output logic [CCAC_MASK_LEN-1:0] capacity_mask_out
);
   logic [CCAC_CLASS_W-1:0] service_class_field_reg;
   logic [CCAC_MASK_LEN-1:0] capacity_mask_reg [CCAC_NUM_CLASS];
   logic reg_done_reg;
   logic reg_gp_fault_reg;
   logic [63:0] reg_rdata_reg;
   logic cache_req_reg;
   logic [CCAC_CLASS_W-1:0] service_class_reg;
   logic [CCAC_MASK_LEN-1:0] capacity_mask_out_reg;

   ccac_id_query u_id_query (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .id_req_in(id_req_in),
      .id_leaf_in(id_leaf_in),
      .id_sub_in(id_sub_in),
      .shared_mask_in(shared_mask_in),
      .no_freq_change_in(no_freq_change_in),
      .id_valid_out(id_valid_out),
      .id_w1_out(id_w1_out),
      .id_w2_out(id_w2_out),
      .id_w3_out(id_w3_out),
      .id_w4_out(id_w4_out)
   );

   // Class number within the reported range, shared by the mask index and class checks
   function automatic logic ccac_class_ok(input logic [31:0] num);
      return num <= {16'h0, CCAC_MAX_CLASS};
   endfunction : ccac_class_ok

   // Address decode
   wire hit_assoc = reg_addr_in == CCAC_ADDR_ASSOC;
   wire in_mask_range = reg_addr_in >= CCAC_ADDR_MASK_LO &&
      reg_addr_in <= CCAC_ADDR_MASK_HI;
   wire [31:0] mask_off = reg_addr_in - CCAC_ADDR_MASK_LO;
   wire mask_idx_ok = in_mask_range && ccac_class_ok(mask_off);
   wire [CCAC_CLASS_W-1:0] mask_idx = mask_off[CCAC_CLASS_W-1:0];
   wire access = reg_rd_in || reg_wr_in;

   // Write checks: class range and reserved bits
   wire [31:0] wr_class = reg_wdata_in[63:CCAC_ASSOC_CLASS_LSB];
   wire assoc_bad = !ccac_class_ok(wr_class) ||
      reg_wdata_in[CCAC_ASSOC_CLASS_LSB-1:0] != 32'h0;
   wire mask_bad = reg_wdata_in[63:CCAC_MASK_LEN] != 48'h0;
   wire wr_fault = reg_wr_in && (hit_assoc ? assoc_bad :
      mask_idx_ok ? mask_bad : 1'b1);
   wire rd_fault = reg_rd_in && !reg_wr_in && !hit_assoc && !mask_idx_ok;
   wire wr_assoc = reg_wr_in && hit_assoc && !assoc_bad;
   wire wr_mask = reg_wr_in && !hit_assoc && mask_idx_ok && !mask_bad;

   // Read data select
   wire [63:0] rd_sel = hit_assoc ?
      {{(32-CCAC_CLASS_W){1'b0}}, service_class_field_reg, 32'h0} :
      mask_idx_ok ? {{(64-CCAC_MASK_LEN){1'b0}}, capacity_mask_reg[mask_idx]} :
      64'h0;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         service_class_field_reg <= CCAC_ASSOC_RST;
      end else if (wr_assoc) begin
         service_class_field_reg <= wr_class[CCAC_CLASS_W-1:0];
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int i = 0; i < CCAC_NUM_CLASS; i++) begin
            capacity_mask_reg[i] <= (i == 0) ? CCAC_MASK0_RST : CCAC_MASKN_RST;
         end
      end else if (wr_mask) begin
         capacity_mask_reg[mask_idx] <= reg_wdata_in[CCAC_MASK_LEN-1:0];
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reg_done_reg <= 1'b0;
         reg_gp_fault_reg <= 1'b0;
         reg_rdata_reg <= 64'h0;
      end else begin
         reg_done_reg <= access;
         reg_gp_fault_reg <= wr_fault || rd_fault;
         if (reg_rd_in && !reg_wr_in) begin
            reg_rdata_reg <= rd_sel;
         end
      end
   end

   // Tag each request with the live class and its mask
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cache_req_reg <= 1'b0;
         service_class_reg <= CCAC_ASSOC_RST;
         capacity_mask_out_reg <= CCAC_MASK0_RST;
      end else begin
         cache_req_reg <= cache_req_in;
         service_class_reg <= service_class_field_reg;
         capacity_mask_out_reg <= capacity_mask_reg[service_class_field_reg];
      end
   end

   assign reg_done_out = reg_done_reg;
   assign reg_gp_fault_out = reg_gp_fault_reg;
   assign reg_rdata_out = reg_rdata_reg;
   assign cache_req_out = cache_req_reg;
   assign service_class_out = service_class_reg;
   assign capacity_mask_out = capacity_mask_out_reg;
endmodule : ccac_top

// [test/ccac_asserts.sv]
// Port checks for the allocation bank: query answers, register faults, tagging.
// Assumes it is bound to ccac_top.
`timescale 1ns/1ps
module ccac_asserts
   import ccac_pkg::*;
(
   input wire logic clk_in, arst_n_in, id_req_in, id_valid_out,
   input wire logic [31:0] id_leaf_in, id_sub_in, id_w1_out, id_w2_out, reg_addr_in,
   input wire logic reg_rd_in, reg_wr_in, reg_done_out, reg_gp_fault_out,
   input wire logic [63:0] reg_wdata_in,
   input wire logic cache_req_in, cache_req_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   sequence q_alloc_s; id_req_in && id_leaf_in == CCAC_LEAF_ALLOC; endsequence
   sequence wr_s(a); reg_wr_in && reg_addr_in == a; endsequence
   sequence mask_wr_s;
      reg_wr_in && reg_addr_in >= CCAC_ADDR_MASK_LO &&
      reg_addr_in <= CCAC_ADDR_MASK_LO + {16'h0, CCAC_MAX_CLASS};
   endsequence
   sequence far_wr_s;
      reg_wr_in && reg_addr_in > CCAC_ADDR_MASK_LO + {16'h0, CCAC_MAX_CLASS} &&
      reg_addr_in <= CCAC_ADDR_MASK_HI;
   endsequence
   id_valid_a: assert property (id_req_in |=> id_valid_out)
      else $error("query not answered");
   feat_flag_a: assert property (id_req_in && id_leaf_in == CCAC_LEAF_FEAT
      && id_sub_in == 0 |=> id_w2_out[15]) else $error("feature flag clear");
   res_map_a: assert property (q_alloc_s ##0 id_sub_in == 0
      |=> id_w2_out == 32'h2) else $error("resource map wrong");
   mask_len_a: assert property (q_alloc_s ##0 id_sub_in == 1
      |=> id_w1_out == 32'hf) else $error("mask length wrong");
   acc_done_a: assert property ((reg_rd_in || reg_wr_in) |=> reg_done_out)
      else $error("access not completed");
   no_done_a: assert property (!reg_rd_in && !reg_wr_in |=> !reg_done_out)
      else $error("spurious completion");
   class_big_a: assert property (wr_s(CCAC_ADDR_ASSOC) ##0 reg_wdata_in[63:36] != 0
      |=> reg_gp_fault_out) else $error("large class accepted");
   mask_rsvd_a: assert property (mask_wr_s ##0 reg_wdata_in[63:16] != 0
      |=> reg_gp_fault_out) else $error("reserved mask bit accepted");
   assoc_rsvd_a: assert property (wr_s(CCAC_ADDR_ASSOC) ##0 reg_wdata_in[31:0] != 0
      |=> reg_gp_fault_out) else $error("reserved class bit accepted");
   class_ok_a: assert property (wr_s(CCAC_ADDR_ASSOC) ##0 reg_wdata_in[63:36] == 0
      && reg_wdata_in[31:0] == 0 |=> !reg_gp_fault_out) else $error("legal class refused");
   far_mask_a: assert property (far_wr_s |=> reg_gp_fault_out)
      else $error("mask beyond class range accepted");
   fault_done_a: assert property (reg_gp_fault_out |-> reg_done_out)
      else $error("fault without completion");
   req_tag_a: assert property (cache_req_in |=> cache_req_out)
      else $error("cache request lost");
endmodule : ccac_asserts
bind ccac_top ccac_asserts chk_i (.clk_in, .arst_n_in, .id_req_in, .id_valid_out,
   .id_leaf_in, .id_sub_in, .id_w1_out, .id_w2_out, .reg_addr_in, .reg_rd_in, .reg_wr_in,
   .reg_done_out, .reg_gp_fault_out, .reg_wdata_in, .cache_req_in, .cache_req_out);

// [test/tb_cache_class_alloc_config.sv]
// Self-checking bench for the allocation bank with random masks and classes.
// Assumes ccac_top and the bound checker.
`timescale 1ns/1ps
module tb_cache_class_alloc_config;
   import ccac_pkg::*;
   logic clk_in = 0, arst_n_in = 0, id_req_in = 0, no_freq_change_in = 0, cache_req_in = 0;
   logic reg_rd_in = 0, reg_wr_in = 0, id_valid_out, reg_done_out, reg_gp_fault_out;
   logic [31:0] shared_mask_in = 0, id_leaf_in = 0, id_sub_in = 0, reg_addr_in = 0;
   logic [31:0] id_w1_out, id_w2_out, id_w3_out, id_w4_out;
   logic [63:0] reg_wdata_in = 0, reg_rdata_out, rd;
   logic cache_req_out, flt;
   logic [3:0] service_class_out, cls, n;
   logic [15:0] capacity_mask_out, mdl [16];
   logic [31:0] fa [5] = '{32'hc8f, 32'hc8f, 32'hc91, 32'hca0, 32'hd8f};
   logic [63:0] fd [5] = '{64'h10_0000_0000, 64'h1, 64'h1_0000, 64'h1, 64'h1};
   int n_errors = 0, checked = 0;
   ccac_top dut (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .shared_mask_in(shared_mask_in),
      .no_freq_change_in(no_freq_change_in),
      .id_req_in(id_req_in),
      .id_leaf_in(id_leaf_in),
      .id_sub_in(id_sub_in),
      .id_valid_out(id_valid_out),
      .id_w1_out(id_w1_out),
      .id_w2_out(id_w2_out),
      .id_w3_out(id_w3_out),
      .id_w4_out(id_w4_out),
      .reg_rd_in(reg_rd_in),
      .reg_wr_in(reg_wr_in),
      .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in),
      .reg_done_out(reg_done_out),
      .reg_rdata_out(reg_rdata_out),
      .reg_gp_fault_out(reg_gp_fault_out),
      .cache_req_in(cache_req_in),
      .cache_req_out(cache_req_out),
      .service_class_out(service_class_out),
      .capacity_mask_out(capacity_mask_out)
   );
   always #50 clk_in = ~clk_in;
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   function automatic logic [63:0] exp_rd(input logic [31:0] a);
      if (a == CCAC_ADDR_ASSOC) return {28'h0, cls, 32'h0};
      return {48'h0, mdl[a[3:0]]};
   endfunction : exp_rd
   task automatic acc(input logic wr, input logic [31:0] a, input logic [63:0] d);
      @(posedge clk_in) #10;
      reg_wr_in = wr;
      reg_rd_in = !wr;
      reg_addr_in = a;
      reg_wdata_in = d;
      @(posedge clk_in) #10;
      reg_wr_in = 0;
      reg_rd_in = 0;
      rd = reg_rdata_out;
      flt = reg_gp_fault_out;
      chk(reg_done_out, 1);
   endtask : acc
   task automatic qry(input logic [31:0] l, input logic [31:0] s);
      @(posedge clk_in) #10;
      id_req_in = 1;
      id_leaf_in = l;
      id_sub_in = s;
      @(posedge clk_in) #10;
      id_req_in = 0;
      chk(id_valid_out, 1);
   endtask : qry
   task results;
      $display("checked %0d, errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   initial begin
      void'($urandom(856));
      foreach (mdl[i]) mdl[i] = 16'h0;
      mdl[0] = 16'hffff;
      cls = 0;
      repeat (8) @(posedge clk_in);
      #10 arst_n_in = 1;
      cache_req_in = 1;
      acc(0, CCAC_ADDR_ASSOC, 0);
      chk(rd, 0);
      for (int i = 0; i < 16; i++) begin
         acc(0, CCAC_ADDR_MASK_LO + i, 0);
         chk(rd, exp_rd(CCAC_ADDR_MASK_LO + i));
         chk(flt, 0);
      end
      chk(capacity_mask_out, 16'hffff);
      chk(service_class_out, 0);
      $display("reset values done");
      shared_mask_in = $urandom;
      no_freq_change_in = 1'($urandom);
      qry(32'h7, 0);
      chk(id_w2_out[15], 1);
      qry(32'h10, 0);
      chk(id_w2_out, 32'h2);
      qry(32'h10, 1);
      chk(id_w1_out, 32'hf);
      chk(id_w2_out, shared_mask_in & 32'hffff);
      chk(id_w3_out, {30'h0, no_freq_change_in, 1'b0});
      chk(id_w4_out, 32'hf);
      qry(32'h10, 2);
      chk(id_w1_out, 0);
      chk(id_w2_out, 0);
      chk(id_w4_out, 0);
      $display("query done");
      repeat (40) begin
         n = 4'($urandom_range(15, 0));
         mdl[n] = 16'hffff << $urandom_range(15, 0);
         acc(1, CCAC_ADDR_MASK_LO + n, {48'h0, mdl[n]});
         chk(flt, 0);
         cls = 4'($urandom_range(15, 0));
         acc(1, CCAC_ADDR_ASSOC, {28'h0, cls, 32'h0});
         chk(flt, 0);
         @(posedge clk_in) #10;
         chk(service_class_out, cls);
         chk(capacity_mask_out, mdl[cls]);
         acc(0, CCAC_ADDR_MASK_LO + n, 0);
         chk(rd, exp_rd(CCAC_ADDR_MASK_LO + n));
      end
      $display("random programming done");
      foreach (fa[i]) begin
         acc(1, fa[i], fd[i]);
         chk(flt, 1);
      end
      acc(0, CCAC_ADDR_ASSOC, 0);
      chk(rd, exp_rd(CCAC_ADDR_ASSOC));
      acc(0, 32'hc91, 0);
      chk(rd, exp_rd(32'hc91));
      acc(0, 32'hca0, 0);
      chk(flt, 1);
      chk(rd, 0);
      $display("faults done");
      @(posedge clk_in) #10;
      arst_n_in = 0;
      #10;
      chk(service_class_out, 0);
      chk(capacity_mask_out, 16'hffff);
      @(posedge clk_in) #10;
      arst_n_in = 1;
      cls = 0;
      foreach (mdl[i]) mdl[i] = (i == 0) ? 16'hffff : 16'h0;
      acc(0, CCAC_ADDR_ASSOC, 0);
      chk(rd, exp_rd(CCAC_ADDR_ASSOC));
      acc(0, CCAC_ADDR_MASK_LO, 0);
      chk(rd, exp_rd(CCAC_ADDR_MASK_LO));
      acc(0, CCAC_ADDR_MASK_LO + n, 0);
      chk(rd, exp_rd(CCAC_ADDR_MASK_LO + n));
      $display("second reset done");
      results;
   end
   initial begin
      #1000000;
      n_errors++;
      results;
   end
endmodule : tb_cache_class_alloc_config
